// *** bench/mfr_link_chk.sv ***
// Link checker for the two ends of the multi-I/O fast read engine.
// Takes the interface signals; one clock domain, async low reset.
`timescale 1ns/1ns
module mfr_link_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] lane
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_nofight;
    (host_oe & dev_oe) == 4'h0;
  endproperty
  a_nofight: assert property (p_nofight)
    else $error("host and device drive a lane together");
  property p_release;
    $rose(cs_n) |-> ##[1:6] (dev_oe == 4'h0);
  endproperty
  a_release: assert property (p_release)
    else $error("device lanes still driven after frame end");
  property p_en_fall;
    $rose(|dev_oe) |-> !sclk;
  endproperty
  a_en_fall: assert property (p_en_fall)
    else $error("device drive enabled while serial clock high");
  property p_chg_low;
    ((|dev_oe) && $changed(dev_o)) |-> !sclk;
  endproperty
  a_chg_low: assert property (p_chg_low)
    else $error("device data changed while serial clock high");
  property p_width;
    (dev_oe == 4'h0) || (dev_oe == 4'h3) || (dev_oe == 4'hF);
  endproperty
  a_width: assert property (p_width)
    else $error("device drives neither two nor four lanes");
  property p_open;
    $fell(cs_n) |-> host_oe[0] && !sclk;
  endproperty
  a_open: assert property (p_open)
    else $error("frame opens without host drive on lane 0");
  property p_half;
    $rose(sclk) |-> sclk[*8] ##[2:13] !sclk;
  endproperty
  a_half: assert property (p_half)
    else $error("serial clock high phase of wrong length");
  property p_idle;
    (cs_n && !sclk) |=> (!sclk || !cs_n);
  endproperty
  a_idle: assert property (p_idle)
    else $error("serial clock toggles outside a frame");
  property p_close;
    $rose(cs_n) |-> sclk;
  endproperty
  a_close: assert property (p_close)
    else $error("frame closed with serial clock low");
  property p_pull;
    (cs_n && $past(cs_n, 8)) |-> (lane == 4'hF);
  endproperty
  a_pull: assert property (p_pull)
    else $error("lane not released high between frames");
endmodule

// *** bench/test_multi_io_fast_read_engine.sv ***
// Testbench: host end facing device end over the link interface.
// Bench models the memory array and drives the host user side.
`timescale 1ns/1ns
module test_multi_io_fast_read_engine;
  import mfr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic qe = 1'b1;
  logic start = 1'b0;
  mfr_cmd_t cmd = MFR_C_DUAL;
  logic [23:0] addr = 24'h0;
  logic [7:0] mode_byte = 8'h00;
  logic [2:0] wrap_set = 3'h1;
  logic [7:0] nbytes = 8'h00;
  logic busy, rd_valid, done, h_cont, d_cont;
  logic [7:0] rd_data, mem_data;
  logic [23:0] mem_addr;
  logic [2:0] wrap_bits;
  logic [7:0] exp_q[$];
  logic [2:0] wq = 3'h1;
  logic cq = 1'b0;
  logic [31:0] r;
  int err_total = 0;
  int n_tests = 0;
  mfr_cmd_t kinds[3] = '{MFR_C_DUAL, MFR_C_QUAD, MFR_C_WORD};

  initial begin
    forever #4 clk = ~clk;
  end

  mfr_link_if u_mfr_link_if();
  mfr_flash_host u_mfr_flash_host (.clk(clk), .rstn(rstn),
    .link(u_mfr_link_if), .start(start), .cmd(cmd), .addr(addr),
    .mode_byte(mode_byte), .wrap_set(wrap_set), .nbytes(nbytes),
    .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .cont_active(h_cont));
  mfr_flash_dev u_mfr_flash_dev (.clk(clk), .rstn(rstn),
    .link(u_mfr_link_if), .quad_io_enable_bit(qe), .mem_addr(mem_addr),
    .mem_data(mem_data), .cont_active(d_cont), .wrap_bits(wrap_bits));
  mfr_link_chk u_mfr_link_chk (.clk(clk), .rstn(rstn),
    .cs_n(u_mfr_link_if.cs_n), .sclk(u_mfr_link_if.sclk),
    .host_o(u_mfr_link_if.host_o), .host_oe(u_mfr_link_if.host_oe),
    .dev_o(u_mfr_link_if.dev_o), .dev_oe(u_mfr_link_if.dev_oe),
    .lane(u_mfr_link_if.lane));

  // Memory contents as a function of address
  function automatic logic [7:0] mval(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
  endfunction
  assign mem_data = mval(mem_addr);

  task automatic test_done;
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bits(input string s, input logic [7:0] e,
      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chk_flag(input string s, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", s, e, g);
    end
  endtask

  // Byte watcher pairs each received byte with the oldest note
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("ERROR rd_data expected none seen %h", rd_data);
      end else begin
        chk_bits("rd_data", exp_q.pop_front(), rd_data);
      end
    end
  end

  task automatic run(input mfr_cmd_t c, input logic [23:0] a,
      input logic [7:0] m, input logic [2:0] w, input logic [7:0] n);
    logic [23:0] b;
    logic [7:0] len;
    int k;
    b = (c == MFR_C_WORD) ? {a[23:1], 1'b0} : a;
    len = MFR_WRAP_MIN << wq[2:1];
    for (int i = 0; i < n; i++) begin
      if (c != MFR_C_DUAL && !qe) begin
        exp_q.push_back(8'hFF);
      end else if (c != MFR_C_DUAL && !wq[0]) begin
        exp_q.push_back(mval({b[23:8], (b[7:0] & ~(len - 8'h1)) |
          ((b[7:0] + 8'(i)) & (len - 8'h1))}));
      end else begin
        exp_q.push_back(mval(b + 24'(i)));
      end
    end
    if (c == MFR_C_WRAP) begin
      wq = w;
    end else if (c == MFR_C_CRMRST) begin
      cq = 1'b0;
    end else if (qe || c == MFR_C_DUAL) begin
      cq = (m[5:4] == MFR_CONT_CODE);
    end
    @(posedge clk);
    start <= 1'b1;
    cmd <= c;
    addr <= a;
    mode_byte <= m;
    wrap_set <= w;
    nbytes <= n;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    chk_flag("busy", 1'b1, busy);
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 8000) begin
      err_total++;
      test_done();
    end
    chk_flag("busy end", 1'b0, busy);
    chk_bits("bytes left", 8'h00, 8'(exp_q.size()));
    exp_q.delete();
    chk_flag("dev cont", cq, d_cont);
    chk_flag("host cont", cq, h_cont);
    chk_bits("wrap_bits", {5'h0, wq}, {5'h0, wrap_bits});
  endtask

  initial begin
    void'($urandom(32'hB5D7));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk_bits("wrap rst", {5'h0, MFR_WRAP_RST}, {5'h0, wrap_bits});
    chk_flag("cont rst", 1'b0, d_cont);
    r = $urandom;
    run(MFR_C_DUAL, r[23:0], 8'h00, 3'h0, 8'h05);
    run(MFR_C_DUAL, 24'hFFFFFE, 8'hEF, 3'h0, 8'h04);
    run(MFR_C_DUAL, r[31:8], 8'h10, 3'h0, 8'h03);
    run(MFR_C_DUAL, r[27:4], 8'h00, 3'h0, 8'h02);
    run(MFR_C_QUAD, r[24:1], 8'h20, 3'h0, 8'h04);
    run(MFR_C_QUAD, r[25:2], 8'hDF, 3'h0, 8'h03);
    run(MFR_C_QUAD, r[26:3], 8'h00, 3'h0, 8'h02);
    run(MFR_C_WORD, r[28:5], 8'hA0, 3'h0, 8'h04);
    run(MFR_C_WORD, r[29:6], 8'hE1, 3'h0, 8'h03);
    run(MFR_C_CRMRST, 24'h0, 8'h00, 3'h0, 8'h00);
    run(MFR_C_WORD, r[30:7], 8'h00, 3'h0, 8'h02);
    for (int l = 0; l < 4; l++) begin
      run(MFR_C_WRAP, 24'h0, 8'h00, {l[1:0], 1'b0}, 8'h00);
      r = $urandom;
      run(l[0] ? MFR_C_WORD : MFR_C_QUAD, {r[15:0], 8'hFA}, 8'h00,
        3'h0, (MFR_WRAP_MIN << l) + 8'h4);
    end
    run(MFR_C_WRAP, 24'h0, 8'h00, 3'h1, 8'h00);
    run(MFR_C_QUAD, {r[15:0], 8'hFA}, 8'h00, 3'h0, 8'h0A);
    @(posedge clk);
    qe <= 1'b0;
    @(posedge clk);
    run(MFR_C_QUAD, r[23:0], 8'h00, 3'h0, 8'h02);
    run(MFR_C_WORD, r[31:8], 8'h00, 3'h0, 8'h02);
    @(posedge clk);
    qe <= 1'b1;
    @(posedge clk);
    repeat (4) begin
      r = $urandom;
      run(kinds[r[1:0] % 3], r[31:8], {r[7:6], 2'b00, r[3:0]}, 3'h0,
        {5'h0, r[6:4]} + 8'h1);
    end
    test_done();
  end
endmodule

// *** src/mfr_flash_dev.sv ***
// Device end: dual and quad I/O fast reads, continuous mode, wrap.
// Memory array sits outside; mem_data follows mem_addr within a few clocks.
`timescale 1ns/1ns
module mfr_flash_dev
  import mfr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  mfr_link_if.dev link,
  input wire logic quad_io_enable_bit,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_data,
  output logic cont_active,
  output logic [2:0] wrap_bits
);
  typedef enum logic [2:0] {
    D_IDLE, D_OP, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_WRAP, D_SKIP
  } mfr_dstate_t;

  mfr_dstate_t st_q;
  mfr_kind_t kind_q;
  mfr_kind_t cont_kind_q;
  logic cont_q;
  logic [7:0] cnt_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [7:0] continuous_mode_byte;
  logic [2:0] wrap_q;
  logic [7:0] sh_q;
  logic [1:0] slot_q;
  logic [3:0] out_q;
  logic [3:0] oe_q;

  logic [5:0] syn_q;
  logic [5:0] syn_rise;
  logic [5:0] syn_fall;
  logic [3:0] ln;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;

  mfr_pin_sync #(.W(6), .INIT({1'b1, 1'b0, MFR_LANES_RST})) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({link.cs_n, link.sclk, link.lane}),
    .q(syn_q),
    .rise(syn_rise),
    .fall(syn_fall)
  );
  assign ln = syn_q[3:0];
  assign cs_rise = syn_rise[5];
  assign cs_fall = syn_fall[5];
  assign sck_rise = syn_rise[4] & ~syn_q[5];
  assign sck_fall = syn_fall[4] & ~syn_q[5];

  // Phase lengths for the current read kind
  logic dual;
  logic [7:0] addr_last;
  logic [7:0] mode_last;
  logic [7:0] dummy_n;
  logic [1:0] slot_last;
  logic [7:0] op_nx;
  logic [7:0] mode_nx;
  logic [23:0] addr_in;

  always_comb begin
    dual = (kind_q == MFR_K_DUAL);
    addr_last = dual ? 8'd11 : 8'd5;
    mode_last = dual ? 8'd3 : 8'd1;
    slot_last = dual ? 2'd3 : 2'd1;
    case (kind_q)
      MFR_K_QUAD: dummy_n = 8'(MFR_DUMMY_QUAD);
      MFR_K_WORD: dummy_n = 8'(MFR_DUMMY_WORD);
      default: dummy_n = 8'h00;
    endcase
    op_nx = {op_q[6:0], ln[0]};
    mode_nx = dual ? {continuous_mode_byte[5:0], ln[1:0]}
                   : {continuous_mode_byte[3:0], ln};
    addr_in = dual ? {addr_q[21:0], ln[1:0]} : {addr_q[19:0], ln};
  end

  // Sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= D_IDLE;
      kind_q <= MFR_K_DUAL;
      cnt_q <= 8'h00;
      op_q <= 8'h00;
    end else if (cs_rise) begin
      st_q <= D_IDLE;
    end else if (cs_fall) begin
      cnt_q <= 8'h00;
      if (cont_q) begin
        st_q <= D_ADDR;
        kind_q <= cont_kind_q;
      end else begin
        st_q <= D_OP;
      end
    end else if (sck_rise) begin
      cnt_q <= cnt_q + 8'h01;
      case (st_q)
        D_OP: begin
          op_q <= op_nx;
          if (cnt_q == 8'(MFR_OP_CLKS - 1)) begin
            cnt_q <= 8'h00;
            case (op_nx)
              MFR_OP_DUAL: begin
                st_q <= D_ADDR;
                kind_q <= MFR_K_DUAL;
              end
              MFR_OP_QUAD: begin
                st_q <= quad_io_enable_bit ? D_ADDR : D_SKIP;
                kind_q <= MFR_K_QUAD;
              end
              MFR_OP_WORD: begin
                st_q <= quad_io_enable_bit ? D_ADDR : D_SKIP;
                kind_q <= MFR_K_WORD;
              end
              MFR_OP_WRAP: st_q <= D_WRAP;
              default: st_q <= D_SKIP;
            endcase
          end
        end
        D_ADDR: begin
          if (cnt_q == addr_last) begin
            cnt_q <= 8'h00;
            st_q <= D_MODE;
          end
        end
        D_MODE: begin
          if (cnt_q == mode_last) begin
            cnt_q <= 8'h00;
            st_q <= (dummy_n == 8'h00) ? D_DATA : D_DUMMY;
          end
        end
        D_DUMMY: begin
          if (cnt_q == dummy_n - 8'h01) begin
            st_q <= D_DATA;
          end
        end
        D_WRAP: begin
          if (cnt_q == 8'(MFR_WRAP_CLKS - 1)) begin
            st_q <= D_SKIP;
          end
        end
        default: cnt_q <= 8'h00;
      endcase
    end
  end

  // next address stays in aligned section when wrap_en is set
  logic wrap_en;
  logic [7:0] wmask;
  logic [7:0] lo_inc;
  logic [23:0] addr_next;
  always_comb begin
    // disable bit set, or dual read, is linear
    wrap_en = ~wrap_q[0] & ~dual;
    wmask = (MFR_WRAP_MIN << wrap_q[2:1]) - 8'h01;
    lo_inc = addr_q[7:0] + 8'h01;
    if (wrap_en) begin
      addr_next = {addr_q[23:8], (addr_q[7:0] & ~wmask) | (lo_inc & wmask)};
    end else begin
      addr_next = addr_q + 24'h000001;
    end
  end

  // Address register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 24'h000000;
    end else if (sck_rise && st_q == D_ADDR) begin
      addr_q <= addr_in;
    end else if (sck_fall && st_q == D_DATA && slot_q == 2'd0) begin
      addr_q <= addr_next;
    end
  end

  // Mode byte and continuous mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      continuous_mode_byte <= 8'h00;
      cont_q <= 1'b0;
      cont_kind_q <= MFR_K_DUAL;
    end else if (sck_rise && st_q == D_MODE) begin
      continuous_mode_byte <= mode_nx;
      if (cnt_q == mode_last) begin
        cont_q <= (mode_nx[5:4] == MFR_CONT_CODE);
        cont_kind_q <= kind_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrap_q <= MFR_WRAP_RST;
    end else if (sck_rise && st_q == D_WRAP &&
                 cnt_q == 8'(MFR_WRAP_CLK)) begin
      wrap_q <= ln[2:0];
    end
  end

  // Data shifter, driven on serial clock falls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= 8'h00;
      slot_q <= 2'd0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (cs_rise || st_q != D_DATA) begin
      slot_q <= 2'd0;
      oe_q <= 4'h0;
    end else if (sck_fall) begin
      slot_q <= (slot_q == slot_last) ? 2'd0 : slot_q + 2'd1;
      if (dual) begin
        oe_q <= 4'h3;
        if (slot_q == 2'd0) begin
          out_q <= {2'b00, mem_data[7:6]};
          sh_q <= {mem_data[5:0], 2'b00};
        end else begin
          out_q <= {2'b00, sh_q[7:6]};
          sh_q <= {sh_q[5:0], 2'b00};
        end
      end else begin
        oe_q <= 4'hF;
        if (slot_q == 2'd0) begin
          out_q <= mem_data[7:4];
          sh_q <= {mem_data[3:0], 4'h0};
        end else begin
          out_q <= sh_q[7:4];
          sh_q <= {sh_q[3:0], 4'h0};
        end
      end
    end
  end

  assign link.dev_o = out_q;
  assign link.dev_oe = oe_q;
  assign mem_addr = addr_q;
  assign cont_active = cont_q;
  assign wrap_bits = wrap_q;
endmodule

// *** src/mfr_flash_host.sv ***
// Host end: issues reads, set-burst and continuous-mode reset.
// Serial clock is divided from clk; idle low, left high at the end.
`timescale 1ns/1ns
module mfr_flash_host
  import mfr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  mfr_link_if.host link,
  input wire logic start,
  input wire mfr_cmd_t cmd,
  input wire logic [23:0] addr,
  input wire logic [7:0] mode_byte,
  input wire logic [2:0] wrap_set,
  input wire logic [7:0] nbytes,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic cont_active
);
  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_GAP
  } mfr_hstate_t;

  mfr_hstate_t st_q;
  logic [4:0] div_q;
  logic tick;
  logic cs_n_q;
  logic sclk_q;
  logic [39:0] sh_q;
  logic [11:0] ci_q;
  logic [11:0] n_q;
  logic [11:0] drv_q;
  logic [11:0] dst_q;
  logic [3:0] opn_q;
  logic [2:0] w_q;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [7:0] rx_q;
  logic [3:0] bits_q;
  logic cont_q;
  logic cont_dual_q;
  logic rd_cmd_q;
  logic [1:0] mcode_q;
  logic [3:0] ln;

  mfr_pin_sync #(.W(4), .INIT(MFR_LANES_RST)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(link.lane),
    .q(ln),
    .rise(),
    .fall()
  );

  function automatic logic [2:0] wcur(input logic [11:0] ci,
    input logic [3:0] opn, input logic [2:0] w);
    return (ci < 12'(opn)) ? 3'd1 : w;
  endfunction

  function automatic logic [3:0] nib(input logic [39:0] s,
    input logic [2:0] w);
    case (w)
      3'd1: nib = {3'b000, s[39]};
      3'd2: nib = {2'b00, s[39:38]};
      default: nib = s[39:36];
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input logic [11:0] ci,
    input logic [11:0] drv, input logic [3:0] opn, input logic [2:0] w);
    if (ci < 12'(opn)) begin
      oe_of = 4'h1;
    end else if (ci < drv) begin
      oe_of = (w == 3'd2) ? 4'h3 : 4'hF;
    end else begin
      oe_of = 4'h0;
    end
  endfunction

  // Command set-up values
  logic [39:0] ld_sh;
  logic [3:0] ld_opn;
  logic [2:0] ld_w;
  logic [11:0] ld_am;
  logic [11:0] ld_dm;
  logic [11:0] ld_dat;
  always_comb begin
    ld_w = 3'd4;
    ld_dm = 12'h000;
    ld_dat = {2'b00, nbytes, 2'b00} >> 1;
    ld_am = 12'(MFR_AM_QUAD);
    ld_opn = cont_q ? 4'h0 : 4'(MFR_OP_CLKS);
    ld_sh = {MFR_OP_QUAD, addr, mode_byte};
    case (cmd)
      MFR_C_DUAL: begin
        // address and mode on two lanes
        ld_w = 3'd2;
        ld_am = 12'(MFR_AM_DUAL);
        ld_dat = {2'b00, nbytes, 2'b00};
        ld_sh = {MFR_OP_DUAL, addr, mode_byte};
      end
      MFR_C_QUAD: ld_dm = 12'(MFR_DUMMY_QUAD);
      MFR_C_WORD: begin
        ld_dm = 12'(MFR_DUMMY_WORD);
        ld_sh = {MFR_OP_WORD, addr[23:1], 1'b0, mode_byte};
      end
      // opcode, 24 dummy bits, wrap bits
      MFR_C_WRAP: begin
        ld_opn = 4'(MFR_OP_CLKS);
        ld_dat = 12'h000;
        ld_am = 12'(MFR_WRAP_CLKS);
        ld_sh = {MFR_OP_WRAP, 24'h000000, 1'b0, wrap_set, 4'h0};
      end
      // all-ones address and mode ends it
      default: begin
        ld_opn = 4'h0;
        ld_dat = 12'h000;
        ld_w = cont_dual_q ? 3'd2 : 3'd4;
        ld_am = cont_dual_q ? 12'(MFR_AM_DUAL) : 12'(MFR_AM_QUAD);
        ld_sh = {40{1'b1}};
      end
    endcase
    if (ld_opn == 4'h0) begin
      ld_sh = {ld_sh[31:0], 8'h00};
    end
  end

  logic [39:0] sh_nx;
  logic [11:0] ci_nx;
  logic [2:0] wc;
  always_comb begin
    wc = wcur(ci_q, opn_q, w_q);
    sh_nx = sh_q << wc;
    ci_nx = ci_q + 12'h001;
  end

  assign tick = (div_q == 5'(MFR_HALF_CYC - 1));

  // Divider and frame sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= H_IDLE;
      div_q <= 5'd0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sh_q <= 40'h0;
      ci_q <= 12'h000;
      n_q <= 12'h000;
      drv_q <= 12'h000;
      dst_q <= 12'h000;
      opn_q <= 4'h0;
      w_q <= 3'd4;
      out_q <= 4'h0;
      oe_q <= 4'h0;
      rd_cmd_q <= 1'b0;
      mcode_q <= 2'b00;
    end else begin
      div_q <= (tick || st_q == H_IDLE) ? 5'd0 : div_q + 5'd1;
      case (st_q)
        H_IDLE: begin
          if (start) begin
            st_q <= H_SETUP;
            cs_n_q <= 1'b0;
            sh_q <= ld_sh;
            ci_q <= 12'h000;
            opn_q <= ld_opn;
            w_q <= ld_w;
            drv_q <= 12'(ld_opn) + ld_am;
            dst_q <= 12'(ld_opn) + ld_am + ld_dm;
            n_q <= 12'(ld_opn) + ld_am + ld_dm + ld_dat;
            out_q <= nib(ld_sh, wcur(12'h000, ld_opn, ld_w));
            oe_q <= oe_of(12'h000, 12'(ld_opn) + ld_am, ld_opn, ld_w);
            rd_cmd_q <= (cmd == MFR_C_DUAL) || (cmd == MFR_C_QUAD) ||
                        (cmd == MFR_C_WORD);
            mcode_q <= mode_byte[5:4];
          end
        end
        H_SETUP, H_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            st_q <= (ci_q == n_q - 12'h001) ? H_END : H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            st_q <= H_LOW;
            sh_q <= sh_nx;
            ci_q <= ci_nx;
            out_q <= nib(sh_nx, wcur(ci_nx, opn_q, w_q));
            oe_q <= oe_of(ci_nx, drv_q, opn_q, w_q);
          end
        end
        H_END: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            oe_q <= 4'h0;
            st_q <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            sclk_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Continuous-mode tracking follows each finished frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cont_q <= 1'b0;
      cont_dual_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (st_q == H_GAP) && tick;
      if (st_q == H_GAP && tick) begin
        if (rd_cmd_q) begin
          cont_q <= (mcode_q == MFR_CONT_CODE);
          cont_dual_q <= (w_q == 3'd2);
        end else if (opn_q == 4'h0) begin
          cont_q <= 1'b0;
        end
      end
    end
  end

  // Read data sampled on serial clock rises
  logic rise_now;
  logic [7:0] rx_nx;
  logic [3:0] bits_nx;
  always_comb begin
    rise_now = (st_q == H_SETUP || st_q == H_LOW) && tick &&
               ci_q >= dst_q;
    rx_nx = (w_q == 3'd2) ? {rx_q[5:0], ln[1:0]} : {rx_q[3:0], ln};
    bits_nx = bits_q + 4'(w_q);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 8'h00;
      bits_q <= 4'h0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (st_q == H_IDLE) begin
        bits_q <= 4'h0;
      end else if (rise_now) begin
        rx_q <= rx_nx;
        bits_q <= (bits_nx == 4'h8) ? 4'h0 : bits_nx;
        if (bits_nx == 4'h8) begin
          rd_data <= rx_nx;
          rd_valid <= 1'b1;
        end
      end
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.host_o = out_q;
  assign link.host_oe = oe_q;
  assign busy = (st_q != H_IDLE);
  assign cont_active = cont_q;
endmodule

// *** src/mfr_link_if.sv ***
// Serial flash link between host and device ends.
// Undriven lanes read high, as with pull-ups on the board.
`timescale 1ns/1ns
interface mfr_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] lane;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (host_oe[i]) begin
        lane[i] = host_o[i];
      end else if (dev_oe[i]) begin
        lane[i] = dev_o[i];
      end else begin
        lane[i] = 1'b1;
      end
    end
  end
  modport host (output cs_n, output sclk, output host_o, output host_oe,
    input lane);
  modport dev (input cs_n, input sclk, input lane, output dev_o,
    output dev_oe);
endinterface

// *** src/mfr_pin_sync.sv ***
// Two-stage synchroniser with edge pulses on the synchronised copy.
// Inputs come from another clock domain or from pins.
`timescale 1ns/1ns
module mfr_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] m_q;
  logic [W-1:0] s_q;
  logic [W-1:0] p_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_q <= INIT;
      s_q <= INIT;
      p_q <= INIT;
    end else begin
      m_q <= d;
      s_q <= m_q;
      p_q <= s_q;
    end
  end
  assign q = s_q;
  assign rise = s_q & ~p_q;
  assign fall = ~s_q & p_q;
endmodule

// *** src/mfr_pkg.sv ***
// Constants and types for the multi-I/O fast read engine and its host.
// Assumes one 125 MHz clock at both ends and a host-made serial clock.
package mfr_pkg;
  localparam logic [7:0] MFR_OP_DUAL = 8'hBB;
  localparam logic [7:0] MFR_OP_QUAD = 8'hEB;
  localparam logic [7:0] MFR_OP_WORD = 8'hE7;
  localparam logic [7:0] MFR_OP_WRAP = 8'h77;
  localparam logic [1:0] MFR_CONT_CODE = 2'h2;
  // Wrap bits {length[1:0], disable}
  localparam logic [2:0] MFR_WRAP_RST = 3'h1;
  localparam logic [7:0] MFR_WRAP_MIN = 8'h08;
  localparam int MFR_WRAP_CLK = 6;
  localparam int MFR_WRAP_CLKS = 8;
  localparam int MFR_OP_CLKS = 8;
  localparam int MFR_AM_DUAL = 16;
  localparam int MFR_AM_QUAD = 8;
  localparam int MFR_DUMMY_QUAD = 4;
  localparam int MFR_DUMMY_WORD = 2;
  localparam int MFR_CLK_NS = 8;
  localparam int MFR_SCLK_NS = 160;
  localparam int MFR_HALF_CYC = MFR_SCLK_NS / (2 * MFR_CLK_NS);
  localparam logic [3:0] MFR_LANES_RST = 4'hF;
  typedef enum logic [1:0] {MFR_K_DUAL, MFR_K_QUAD, MFR_K_WORD} mfr_kind_t;
  typedef enum logic [2:0] {
    MFR_C_DUAL, MFR_C_QUAD, MFR_C_WORD, MFR_C_WRAP, MFR_C_CRMRST
  } mfr_cmd_t;
endpackage
